// file: src/tgim_defines.svh
// constants of the two-group interrupt manager: bit positions, widths, reset values
// assumes inclusion by bare name from the package file only; the design modules use the macros without including it
`ifndef TGIM_DEFINES_SVH
`define TGIM_DEFINES_SVH

// request lines and group line select width
`define TGIM_LINE_COUNT 8
`define TGIM_SELECT_WIDTH 3
`define TGIM_EXT_COUNT 2
// latched conditions per group (buffer request is a level, not latched)
`define TGIM_LATCHED_COUNT 8
// enable vector width: latched conditions plus the buffer request
`define TGIM_ENABLE_WIDTH 9

// group A latched condition positions
`define TGIM_A_ERROR 0
`define TGIM_A_START 1
`define TGIM_A_STOP 2
`define TGIM_A_FIRST_START 3
`define TGIM_A_SECOND_START 4
`define TGIM_A_SCAN_COUNT 5
`define TGIM_A_COUNTER_TERMINAL 6
`define TGIM_A_COUNTER_GATE 7
// group B latched condition positions
`define TGIM_B_ERROR 0
`define TGIM_B_STOP 1
`define TGIM_B_START 2
`define TGIM_B_FIRST_START 3
`define TGIM_B_BUFFER_COUNT 4
`define TGIM_B_UPDATE_COUNT 5
`define TGIM_B_COUNTER_TERMINAL 6
`define TGIM_B_COUNTER_GATE 7
// enable bit of the buffer request, both groups
`define TGIM_BUFFER_ENABLE_BIT 8

// external input index per group
`define TGIM_EXT_GROUP_A 0
`define TGIM_EXT_GROUP_B 1

// reset values
`define TGIM_PENDING_RESET 8'h00
`define TGIM_SYNC_RESET 2'h0
`define TGIM_LINE_RESET 8'h00
`define TGIM_SECOND_RESET 2'h0
`define TGIM_FLAG_RESET 1'h0

`endif

// file: src/tgim_pkg.sv
// types shared by the interrupt manager modules
// assumes tgim_defines.svh is on the include path
`include "tgim_defines.svh"

package tgim_pkg;

  // registered state of the top module
  typedef struct packed {
    logic [`TGIM_EXT_COUNT-1:0]  syncFirst;   // first synchroniser stage of the ext pins
    logic [`TGIM_EXT_COUNT-1:0]  syncSecond;  // second stage, the only one logic reads
    logic [`TGIM_LINE_COUNT-1:0] lineDrive;   // request line enables
    logic [`TGIM_LINE_COUNT-1:0] lineLevel;   // level driven on enabled lines
    logic [`TGIM_EXT_COUNT-1:0]  secondDrive; // secondary output enables
    logic                        summaryA;    // group A asserted
    logic                        summaryB;    // group B asserted
  } tgim_state_type;

endpackage

// file: src/tgim_sticky.sv
// bank of sticky status bits: a set pulse latches, a clear pulse releases
// assumes set and clear come from logic on the same clock
`timescale 1ns/10ps

module tgim_sticky
  import tgim_pkg::*;
#(
  parameter int WIDTH = `TGIM_LATCHED_COUNT
) (
  input  wire logic             clock,      // device clock
  input  wire logic             rst_b,      // asynchronous reset, active low
  input  wire logic [WIDTH-1:0] setPulse,   // condition occurred this cycle
  input  wire logic [WIDTH-1:0] clearPulse, // acknowledge written this cycle
  output logic      [WIDTH-1:0] pending     // latched status
);

  // whole state of the bank
  typedef struct packed {
    logic [WIDTH-1:0] pending; // one bit per condition
  } tgim_sticky_state_type;

  tgim_sticky_state_type state;      // current state
  tgim_sticky_state_type next_state; // state for the next edge

  // next state: clear first, then set, so a fresh event is never lost
  always_comb begin
    next_state = state;
    next_state.pending = (state.pending & ~clearPulse) | setPulse;
  end

  // register the bank
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state.pending <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign pending = state.pending;

endmodule

// file: src/two_group_interrupt_manager.sv
// two-group interrupt manager: latches internal conditions, takes two external
// interrupt inputs, and drives eight open-drain request lines and two secondary lines
// assumes condition events and acknowledges are single-cycle pulses on this clock,
// error flags are levels on this clock, and the ext inputs are asynchronous pins
//
// Overview of operation
// - eighteen internal conditions, two external inputs
// - eight request outputs, two external inputs
// - one polarity bit for all lines
// - three-pin option duplicates onto lines 0,1
// - per-group enable gates its selected line
// - both groups may pick one line
// - per-input polarity, 1 means active low
// - per-input enable into its group
// - per-input enable to secondary output
// - group A: input timing, counter 0, ext0
// - group B: output timing, counter 1, ext1
// - groups independent, any of eight lines
// - external status follows the input level
// - counter-0 terminal acknowledge clears status
// - counter-0 gate acknowledge clears status
// - scan-count acknowledge clears its status
// - start, starts, stop latch; acknowledges clear
// - error from overrun or overflow, acknowledgeable
// - shared line asserts only that line
// - three-pin lines follow either group's request
// - summary reports any asserted group A interrupt
`timescale 1ns/10ps

module two_group_interrupt_manager
  import tgim_pkg::*;
(
  input  wire logic                           clock,                   // 125 MHz device clock
  input  wire logic                           rst_b,                   // asynchronous reset
  // line configuration
  input  wire logic                           outputPolarity,          // 0 active high, 1 active low
  input  wire logic                           threePinOption,          // mirror onto lines 0 and 1
  input  wire logic                           groupAEnable,            // group A may drive
  input  wire logic [`TGIM_SELECT_WIDTH-1:0]  groupASelect,            // group A line number
  input  wire logic                           groupBEnable,            // group B may drive
  input  wire logic [`TGIM_SELECT_WIDTH-1:0]  groupBSelect,            // group B line number
  // external inputs
  input  wire logic [`TGIM_EXT_COUNT-1:0]     extIn,                   // external interrupt pins
  input  wire logic [`TGIM_EXT_COUNT-1:0]     extPolarity,             // 0 high active, 1 low
  input  wire logic [`TGIM_EXT_COUNT-1:0]     extEnable,               // into the group
  input  wire logic [`TGIM_EXT_COUNT-1:0]     extSecondEnable,         // onto the secondary line
  // group A conditions
  input  wire logic                           inputOverrunFlag,        // input timing overrun
  input  wire logic                           inputOverflowFlag,       // input buffer overflow
  input  wire logic                           inputStartEvent,         // start seen
  input  wire logic                           inputStopEvent,          // stop seen
  input  wire logic                           inputFirstStartEvent,    // first start seen
  input  wire logic                           inputSecondStartEvent,   // second start seen
  input  wire logic                           inputScanCountEvent,     // scan count terminal
  input  wire logic                           counter0TerminalEvent,   // counter 0 terminal
  input  wire logic                           counter0GateEvent,       // counter 0 gate event
  input  wire logic                           inputBufferRequest,      // buffer condition level
  // group A acknowledges
  input  wire logic                           input_error_clear,       // error acknowledge
  input  wire logic                           input_start_clear,       // start acknowledge
  input  wire logic                           input_stop_clear,        // stop acknowledge
  input  wire logic                           input_first_start_clear, // first start ack
  input  wire logic                           input_second_start_clear,// second start ack
  input  wire logic                           input_scan_count_clear,  // scan count ack
  input  wire logic                           counter0_terminal_clear, // counter 0 terminal ack
  input  wire logic                           counter0_gate_clear,     // counter 0 gate ack
  input  wire logic [`TGIM_ENABLE_WIDTH-1:0]  groupAConditionEnable,   // per-condition masks
  // group B conditions, bit layout in the defines
  input  wire logic [`TGIM_LATCHED_COUNT-1:0] outputConditionSet,      // events or error level
  input  wire logic [`TGIM_LATCHED_COUNT-1:0] outputConditionClear,    // acknowledges
  input  wire logic                           outputBufferRequest,     // buffer condition level
  input  wire logic [`TGIM_ENABLE_WIDTH-1:0]  groupBConditionEnable,   // per-condition masks
  // request lines, open drain
  output logic      [`TGIM_LINE_COUNT-1:0]    irqOut,                  // level while enabled
  output logic      [`TGIM_LINE_COUNT-1:0]    irqOutEnable,            // high while driving
  output logic      [`TGIM_EXT_COUNT-1:0]     secondOut,               // secondary level
  output logic      [`TGIM_EXT_COUNT-1:0]     secondOutEnable,         // secondary drive
  // status
  output logic                                group_a_summary,         // group A asserted
  output logic                                groupBSummary,           // group B asserted
  output logic                                ext0_pending,            // ext input 0 active
  output logic                                ext1Pending,             // ext input 1 active
  output logic                                counter0_terminal_pending, // latched terminal
  output logic                                counter0_gate_pending,   // latched gate event
  output logic      [`TGIM_LATCHED_COUNT-1:0] groupAPending,           // latched group A bits
  output logic      [`TGIM_LATCHED_COUNT-1:0] groupBPending            // latched group B bits
);

  tgim_state_type                  state;      // registered state
  tgim_state_type                  next_state; // next registered state
  logic [`TGIM_LATCHED_COUNT-1:0]  setA;       // group A set pulses
  logic [`TGIM_LATCHED_COUNT-1:0]  clearA;     // group A acknowledges
  logic [`TGIM_EXT_COUNT-1:0]      extActive;  // polarity-corrected ext level
  logic                            requestA;   // group A wants a line
  logic                            requestB;   // group B wants a line

  // gather group A sources into one vector
  // nine internal sources into eight latched bits
  always_comb begin
    setA = '0;
    setA[`TGIM_A_ERROR]             = inputOverrunFlag | inputOverflowFlag;
    setA[`TGIM_A_START]             = inputStartEvent;
    setA[`TGIM_A_STOP]              = inputStopEvent;
    setA[`TGIM_A_FIRST_START]       = inputFirstStartEvent;
    setA[`TGIM_A_SECOND_START]      = inputSecondStartEvent;
    setA[`TGIM_A_SCAN_COUNT]        = inputScanCountEvent;
    setA[`TGIM_A_COUNTER_TERMINAL]  = counter0TerminalEvent;
    setA[`TGIM_A_COUNTER_GATE]      = counter0GateEvent;
  end

  // gather group A acknowledges; each one clears only its own bit
  always_comb begin
    clearA = '0;
    clearA[`TGIM_A_ERROR]            = input_error_clear;
    clearA[`TGIM_A_START]            = input_start_clear;
    clearA[`TGIM_A_STOP]             = input_stop_clear;
    clearA[`TGIM_A_FIRST_START]      = input_first_start_clear;
    clearA[`TGIM_A_SECOND_START]     = input_second_start_clear;
    clearA[`TGIM_A_SCAN_COUNT]       = input_scan_count_clear;
    clearA[`TGIM_A_COUNTER_TERMINAL] = counter0_terminal_clear;
    clearA[`TGIM_A_COUNTER_GATE]     = counter0_gate_clear;
  end

  tgim_sticky #(
    .WIDTH (`TGIM_LATCHED_COUNT)
  ) groupALatch (
    .clock      (clock),
    .rst_b      (rst_b),
    .setPulse   (setA),
    .clearPulse (clearA),
    .pending    (groupAPending)
  );

  tgim_sticky #(
    .WIDTH (`TGIM_LATCHED_COUNT)
  ) groupBLatch (
    .clock      (clock),
    .rst_b      (rst_b),
    .setPulse   (outputConditionSet),
    .clearPulse (outputConditionClear),
    .pending    (groupBPending)
  );

  // polarity-corrected external levels, read only from the second sync stage
  always_comb begin
    extActive = state.syncSecond ^ extPolarity;
  end

  // group requests: OR of enabled pending bits, buffer levels and ext inputs
  always_comb begin
    requestA = (|(groupAPending & groupAConditionEnable[`TGIM_LATCHED_COUNT-1:0]))
             | (inputBufferRequest & groupAConditionEnable[`TGIM_BUFFER_ENABLE_BIT])
             | (extActive[`TGIM_EXT_GROUP_A] & extEnable[`TGIM_EXT_GROUP_A]);
    requestB = (|(groupBPending & groupBConditionEnable[`TGIM_LATCHED_COUNT-1:0]))
             | (outputBufferRequest & groupBConditionEnable[`TGIM_BUFFER_ENABLE_BIT])
             | (extActive[`TGIM_EXT_GROUP_B] & extEnable[`TGIM_EXT_GROUP_B]);
  end

  // next state: synchronisers, line routing, secondary lines, summaries
  always_comb begin
    next_state = state;
    // two-stage synchroniser; stage one feeds stage two and nothing else
    next_state.syncFirst  = extIn;
    next_state.syncSecond = state.syncFirst;
    next_state.lineLevel  = outputPolarity ? `TGIM_LINE_RESET : ~`TGIM_LINE_RESET;
    for (int i = 0; i < `TGIM_LINE_COUNT; i++) begin
      // a shared line is one line
      next_state.lineDrive[i] =
          (groupAEnable & requestA & (groupASelect == i[`TGIM_SELECT_WIDTH-1:0]))
        | (groupBEnable & requestB & (groupBSelect == i[`TGIM_SELECT_WIDTH-1:0]));
    end
    // mirror onto lines 0 and 1
    if (threePinOption) begin
      next_state.lineDrive[0] = next_state.lineDrive[0]
                              | (groupAEnable & requestA) | (groupBEnable & requestB);
      next_state.lineDrive[1] = next_state.lineDrive[1]
                              | (groupAEnable & requestA) | (groupBEnable & requestB);
    end
    next_state.secondDrive = extActive & extSecondEnable;
    next_state.summaryA = requestA;
    next_state.summaryB = requestB;
  end

  // register the state; every bit takes a constant under reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state.syncFirst   <= `TGIM_SYNC_RESET;
      state.syncSecond  <= `TGIM_SYNC_RESET;
      state.lineDrive   <= `TGIM_LINE_RESET;
      state.lineLevel   <= `TGIM_LINE_RESET;
      state.secondDrive <= `TGIM_SECOND_RESET;
      state.summaryA    <= `TGIM_FLAG_RESET;
      state.summaryB    <= `TGIM_FLAG_RESET;
    end else begin
      state <= next_state;
    end
  end

  // open-drain request lines: level is constant per polarity, enable does the work
  // the pin stays released while no group asks, so the board pull-up decides it
  // eight request lines
  assign irqOut          = state.lineLevel;
  assign irqOutEnable    = state.lineDrive;
  // secondary lines share the polarity setting with the request lines
  assign secondOut       = state.lineLevel[`TGIM_EXT_COUNT-1:0];
  assign secondOutEnable = state.secondDrive;

  // status outputs from flip-flops; the ext status also XORs in the live extPolarity input
  assign group_a_summary           = state.summaryA;
  assign groupBSummary             = state.summaryB;
  assign ext0_pending              = state.syncSecond[`TGIM_EXT_GROUP_A] ^ extPolarity[`TGIM_EXT_GROUP_A];
  assign ext1Pending               = state.syncSecond[`TGIM_EXT_GROUP_B] ^ extPolarity[`TGIM_EXT_GROUP_B];
  assign counter0_terminal_pending = groupAPending[`TGIM_A_COUNTER_TERMINAL];
  assign counter0_gate_pending     = groupAPending[`TGIM_A_COUNTER_GATE];

endmodule

// file: testbench/tgim_bus_model.sv
// host side of the request wires: open-drain lines with pull-ups
// assumes level/enable pairs from the manager; a released line floats high
`timescale 1ns/10ps

module tgim_bus_model
  import tgim_pkg::*;
(
  input  wire logic [7:0] irqOut,          // level while driven
  input  wire logic [7:0] irqOutEnable,    // drive enables
  input  wire logic [1:0] secondOut,       // secondary level
  input  wire logic [1:0] secondOutEnable, // secondary enables
  output logic      [7:0] irqLine,         // resolved request wires
  output logic      [1:0] secondLine       // resolved secondary wires
);
  // pull-up wire resolution
  // released wires show the pull-up, never the last driven level
  always_comb begin
    for (int i = 0; i < 8; i++) irqLine[i] = irqOutEnable[i] ? irqOut[i] : 1'h1;
    for (int i = 0; i < 2; i++) secondLine[i] = secondOutEnable[i] ? secondOut[i] : 1'h1;
  end
endmodule

// file: testbench/tgim_props.sv
// timing checks of the interrupt manager ports: latches, lines, pass-through
// assumes one clock domain with the asynchronous active-low reset
`timescale 1ns/10ps

module tgim_props
  import tgim_pkg::*;
(
  input wire logic       clock,                     // device clock
  input wire logic       rst_b,                     // reset, active low
  input wire logic       outputPolarity,            // line polarity
  input wire logic       threePinOption,            // mirror option
  input wire logic       groupAEnable,              // group A drive enable
  input wire logic [2:0] groupASelect,              // group A line
  input wire logic       groupBEnable,              // group B drive enable
  input wire logic [2:0] groupBSelect,              // group B line
  input wire logic [1:0] extIn,                     // external pins
  input wire logic [1:0] extPolarity,               // external polarity
  input wire logic       inputOverrunFlag,          // overrun level
  input wire logic       inputOverflowFlag,         // overflow level
  input wire logic       counter0TerminalEvent,     // terminal pulse
  input wire logic       counter0_terminal_clear,   // terminal acknowledge
  input wire logic [8:0] groupAConditionEnable,     // group A masks
  input wire logic [7:0] irqOut,                    // line levels
  input wire logic [7:0] irqOutEnable,              // line enables
  input wire logic       group_a_summary,           // group A request
  input wire logic       groupBSummary,             // group B request
  input wire logic       ext0_pending,              // ext 0 status
  input wire logic       counter0_terminal_pending, // latched terminal
  input wire logic [7:0] groupAPending              // latched group A bits
);
  logic [1:0] upCount; // edges since reset, saturates at three

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  // the synchroniser check waits out its fill time after reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) upCount <= 2'h0;
    else if (upCount != 2'h3) upCount <= upCount + 2'h1;
  end

  property p_level; (irqOutEnable != 8'h00) |-> (irqOut == {8{~$past(outputPolarity)}}); endproperty
  a_level: assert property (p_level) else $error("line level disagrees with polarity");
  property p_termSet; counter0TerminalEvent |=> counter0_terminal_pending; endproperty
  a_termSet: assert property (p_termSet) else $error("terminal event not latched");
  property p_termClr; counter0_terminal_clear && !counter0TerminalEvent |=> !counter0_terminal_pending; endproperty
  a_termClr: assert property (p_termClr) else $error("terminal acknowledge ignored");
  property p_error; (inputOverrunFlag || inputOverflowFlag) |=> groupAPending[0]; endproperty
  a_error: assert property (p_error) else $error("error flag not latched");
  property p_ext; (upCount == 2'h3) |-> (ext0_pending == ($past(extIn[0], 2) ^ extPolarity[0])); endproperty
  a_ext: assert property (p_ext) else $error("ext status does not follow pin");
  property p_lineA; $past(groupAEnable) && group_a_summary |-> irqOutEnable[$past(groupASelect)]; endproperty
  a_lineA: assert property (p_lineA) else $error("group A line not driven");
  property p_off; !$past(groupAEnable) && !$past(groupBEnable) |-> (irqOutEnable == 8'h00); endproperty
  a_off: assert property (p_off) else $error("line driven with groups disabled");
  property p_route;
    !$past(threePinOption) |->
      ((irqOutEnable & ~((8'h01 << $past(groupASelect)) | (8'h01 << $past(groupBSelect)))) == 8'h00);
  endproperty
  a_route: assert property (p_route) else $error("unselected line driven");
  property p_three; $past(threePinOption) && $past(groupBEnable) && groupBSummary |-> (irqOutEnable[1:0] == 2'h3); endproperty
  a_three: assert property (p_three) else $error("mirror lines not driven");
  property p_sum; (|(groupAPending & groupAConditionEnable[7:0])) |=> group_a_summary; endproperty
  a_sum: assert property (p_sum) else $error("group A summary missing");
endmodule

bind two_group_interrupt_manager tgim_props u_props (
  .clock, .rst_b, .outputPolarity, .threePinOption, .groupAEnable, .groupASelect, .groupBEnable,
  .groupBSelect, .extIn, .extPolarity, .inputOverrunFlag, .inputOverflowFlag, .counter0TerminalEvent,
  .counter0_terminal_clear, .groupAConditionEnable, .irqOut, .irqOutEnable, .group_a_summary,
  .groupBSummary, .ext0_pending, .counter0_terminal_pending, .groupAPending
);

// file: testbench/two_group_interrupt_manager_test.sv
// self-checking bench of the interrupt manager with the pull-up wire model
// assumes the src files compile first; inputs change on the falling edge
`timescale 1ns/10ps

module two_group_interrupt_manager_test
  import tgim_pkg::*;
;
  logic       clock, rst_b, outputPolarity, threePinOption, groupAEnable, groupBEnable; // clock and config
  logic [2:0] groupASelect, groupBSelect;                             // line numbers
  logic [1:0] extIn, extPolarity, extEnable, extSecondEnable;         // pass-through controls
  logic [7:0] aSet, aClr;                                             // group A events and acknowledges
  logic       inputOverflowFlag, inputBufferRequest, outputBufferRequest; // levels
  logic [8:0] groupAConditionEnable, groupBConditionEnable;           // per-condition masks
  logic [7:0] outputConditionSet, outputConditionClear;               // group B events and acknowledges
  logic [7:0] irqOut, irqOutEnable, irqLine, groupAPending, groupBPending; // observed
  logic [1:0] secondOut, secondOutEnable, secondLine;                 // secondary side
  logic       group_a_summary, groupBSummary, ext0_pending, ext1Pending; // status
  logic       counter0_terminal_pending, counter0_gate_pending;       // latched counter 0 bits
  int         errCount, nTests;                                       // mismatches and comparisons

  // a single event vector keeps the per-bit loops short
  two_group_interrupt_manager uut (
    .clock, .rst_b, .outputPolarity, .threePinOption, .groupAEnable, .groupASelect, .groupBEnable,
    .groupBSelect, .extIn, .extPolarity, .extEnable, .extSecondEnable, .inputOverrunFlag(aSet[0]),
    .inputOverflowFlag, .inputStartEvent(aSet[1]), .inputStopEvent(aSet[2]), .inputFirstStartEvent(aSet[3]),
    .inputSecondStartEvent(aSet[4]), .inputScanCountEvent(aSet[5]), .counter0TerminalEvent(aSet[6]),
    .counter0GateEvent(aSet[7]), .inputBufferRequest, .input_error_clear(aClr[0]), .input_start_clear(aClr[1]),
    .input_stop_clear(aClr[2]), .input_first_start_clear(aClr[3]), .input_second_start_clear(aClr[4]),
    .input_scan_count_clear(aClr[5]), .counter0_terminal_clear(aClr[6]), .counter0_gate_clear(aClr[7]),
    .groupAConditionEnable, .outputConditionSet, .outputConditionClear, .outputBufferRequest,
    .groupBConditionEnable, .irqOut, .irqOutEnable, .secondOut, .secondOutEnable, .group_a_summary,
    .groupBSummary, .ext0_pending, .ext1Pending, .counter0_terminal_pending, .counter0_gate_pending,
    .groupAPending, .groupBPending
  );

  tgim_bus_model host (.irqOut, .irqOutEnable, .secondOut, .secondOutEnable, .irqLine, .secondLine);

  // free-running 8 ns clock
  initial begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    nTests++;
    if (seen !== exp) begin
      errCount++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic closeOut();
    $display("comparisons %0d, mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // buffer levels drive the routing; polarity and lines settle before enables
  task automatic route(input logic pol, aEn, input logic [2:0] aSel, input logic bEn,
                       input logic [2:0] bSel, input logic three, a, b, input logic [7:0] exp);
    {outputPolarity, groupASelect, groupBSelect, threePinOption} = {pol, aSel, bSel, three};
    @(negedge clock);
    {groupAEnable, groupBEnable, inputBufferRequest, outputBufferRequest} = {aEn, bEn, a, b};
    repeat (2) @(negedge clock);
    check(irqOutEnable, exp);
    check(irqLine, pol ? ~exp : 8'hFF);
    check({groupBSummary, group_a_summary}, {b, a});
    {groupAEnable, groupBEnable, inputBufferRequest, outputBufferRequest} = 4'h0;
    repeat (2) @(negedge clock);
  endtask

  // pins pass two synchroniser stages before the line follows
  task automatic extCase(input logic [1:0] pin, en, sec, input logic [7:0] exp, input logic [1:0] expSec);
    {extIn, extEnable, extSecondEnable} = {pin, en, sec};
    repeat (4) @(negedge clock);
    check({ext1Pending, ext0_pending}, pin ^ extPolarity);
    check(irqOutEnable, exp);
    check(secondOutEnable, expSec);
    check(secondLine, {6'h00, ~expSec});
  endtask

  // main sequence
  initial begin
    {rst_b, outputPolarity, threePinOption, groupAEnable, groupBEnable, groupASelect, groupBSelect} = '0;
    {extIn, extPolarity, extEnable, extSecondEnable, aSet, aClr, inputOverflowFlag} = '0;
    {inputBufferRequest, outputBufferRequest, groupAConditionEnable, groupBConditionEnable} = '0;
    {outputConditionSet, outputConditionClear, errCount, nTests} = '0;
    repeat (8) @(negedge clock);
    rst_b = 1'h1;
    check(irqOutEnable, 8'h00);
    groupAConditionEnable = 9'h0FF;
    for (int i = 0; i < 8; i++) begin
      aSet = 8'h01 << i;
      @(negedge clock);
      aSet = 8'h00;
      check(groupAPending, 8'h01 << i);
      check({counter0_gate_pending, counter0_terminal_pending}, (8'h01 << i) >> 6);
      {aSet, aClr} = {8'h01 << i, 8'h01 << i};
      @(negedge clock);
      aSet = 8'h00;
      check(groupAPending, 8'h01 << i);
      @(negedge clock);
      aClr = 8'h00;
      check(groupAPending, 8'h00);
      outputConditionSet = 8'h01 << i;
      @(negedge clock);
      {outputConditionSet, outputConditionClear} = {8'h00, 8'h01 << i};
      check(groupBPending, 8'h01 << i);
      @(negedge clock);
      outputConditionClear = 8'h00;
      check(groupBPending, 8'h00);
    end
    inputOverflowFlag = 1'h1;
    @(negedge clock);
    {inputOverflowFlag, aClr} = {1'h0, 8'h01};
    check(groupAPending, 8'h01);
    @(negedge clock);
    aClr = 8'h00;
    {groupAConditionEnable, groupBConditionEnable} = {9'h100, 9'h100};
    for (int s = 0; s < 8; s++) begin
      route(s[0], 1'h1, s[2:0], 1'h0, 3'h0, 1'h0, 1'h1, 1'h0, 8'h01 << s);
      route(~s[0], 1'h0, 3'h0, 1'h1, s[2:0], 1'h0, 1'h0, 1'h1, 8'h01 << s);
    end
    route(1'h1, 1'h1, 3'h5, 1'h1, 3'h5, 1'h0, 1'h1, 1'h1, 8'h20);
    route(1'h0, 1'h1, 3'h2, 1'h1, 3'h6, 1'h0, 1'h1, 1'h1, 8'h44);
    route(1'h1, 1'h1, 3'h2, 1'h1, 3'h6, 1'h1, 1'h0, 1'h1, 8'h43);
    route(1'h0, 1'h1, 3'h4, 1'h0, 3'h0, 1'h1, 1'h1, 1'h0, 8'h13);
    route(1'h1, 1'h0, 3'h3, 1'h0, 3'h4, 1'h1, 1'h1, 1'h1, 8'h00);
    {groupAConditionEnable, groupBConditionEnable, outputPolarity, extPolarity, extIn} = {18'h0, 1'h1, 2'h3, 2'h3};
    {groupASelect, groupBSelect, threePinOption} = {3'h3, 3'h7, 1'h0};
    @(negedge clock);
    {groupAEnable, groupBEnable} = 2'h3;
    extCase(2'h2, 2'h1, 2'h1, 8'h08, 2'h1);
    extCase(2'h3, 2'h1, 2'h1, 8'h00, 2'h0);
    extCase(2'h0, 2'h0, 2'h0, 8'h00, 2'h0);
    extCase(2'h1, 2'h2, 2'h2, 8'h80, 2'h2);
    extCase(2'h3, 2'h0, 2'h0, 8'h00, 2'h0);
    extPolarity = 2'h0;
    extCase(2'h1, 2'h1, 2'h0, 8'h08, 2'h0);
    closeOut();
  end

  // hang guard well beyond the under two hundred cycles of the sequence
  initial begin
    #20000;
    errCount++;
    closeOut();
  end
endmodule
